// [hdl/cpe_pkg.sv]
package cpe_pkg;
   localparam int          CLK_HZ     = 250_000_000;
   localparam int          BAUD       = 115_200;
   localparam int          BIT_CYC    = CLK_HZ / BAUD;
   localparam logic [11:0] BIT_LAST   = 12'(BIT_CYC - 1);
   localparam logic [11:0] HALF_BIT   = 12'(BIT_CYC / 2);
   localparam logic [15:0] ID_ERASE   = 16'h7765;
   localparam logic [15:0] ID_PROGRAM = 16'h7777;
   localparam logic [15:0] ID_RESTART = 16'h7a7a;
   localparam logic [32:0] STORE_MAX  = 33'h0_0006_0000;
   localparam logic [31:0] PROG_MAX   = 32'h0000_0400;
   localparam logic [7:0]  RC_OK      = 8'h00;
   localparam logic [7:0]  RC_RANGE   = 8'h01;
   localparam logic [7:0]  RC_UNKNOWN = 8'h02;
   localparam logic [31:0] IP_DEFAULT = 32'hc0a8_0001;
   localparam int          ENTRIES    = 64;
   localparam int          TYPE_MSB   = 31;
   localparam int          TYPE_LSB   = 28;
   localparam int          GRP_MSB    = 27;
   localparam int          GRP_LSB    = 14;
   localparam int          MEM_MSB    = 13;
   localparam logic [3:0]  T_EMPTY    = 4'h0;
   localparam logic [3:0]  T_CARD_EN  = 4'h1;
   localparam logic [3:0]  T_GROUP_EN = 4'h2;
   localparam logic [3:0]  T_CARD_BLK = 4'h3;
   localparam int          BLINK_W    = 24;

   typedef enum logic [2:0]
   {
      S_IDLE = 3'h0, S_ID2 = 3'h1, S_PAR = 3'h3, S_DATA = 3'h2,
      S_RESP = 3'h6, S_WTX = 3'h7, S_RST = 3'h5, S_ERASE = 3'h4
   } cpe_st_e;

   typedef struct packed
   {
      cpe_st_e                    st;
      logic                       rx_s1, rx_s2, rx_busy;
      logic [11:0]                rx_cnt;
      logic [3:0]                 rx_bit;
      logic [7:0]                 rx_sh;
      logic                       tx_busy;
      logic [11:0]                tx_cnt;
      logic [3:0]                 tx_bit;
      logic [9:0]                 tx_sh;
      logic [15:0]                cmd;
      logic [31:0]                addr, cnt;
      logic [2:0]                 nib;
      logic [7:0]                 rc;
      logic                       err, mem_we, erase_req, proc_rst;
      logic [18:0]                mem_addr;
      logic [7:0]                 mem_data;
      logic [31:0]                ip;
      logic                       ipr1, ipr2;
      logic [1:0]                 boot;
      logic [2:0]                 ph1, ph2;
      logic [BLINK_W-1:0]         blink;
      logic                       led_g, led_y, grant;
      logic [ENTRIES-1:0][31:0]   tbl;
   } cpe_state_s;
endpackage : cpe_pkg

// [hdl/cpe_engine.sv]
module cpe_engine
#(
   // Clocks per serial bit
   parameter int BIT_CYC = cpe_pkg::BIT_CYC
)
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Serial configuration port
   input  wire logic        cfg_rxd,
   output logic             cfg_txd,
   // Page store
   output logic             store_wr,
   output logic [18:0]      store_addr,
   output logic [7:0]       store_data,
   output logic             erase_req,
   output logic [31:0]      erase_start,
   output logic [31:0]      erase_len,
   input  wire logic        erase_done,
   output logic             proc_reset,
   // Authorization table
   input  wire logic        tbl_wr,
   input  wire logic [5:0]  tbl_idx,
   input  wire logic [31:0] tbl_data,
   input  wire logic [27:0] card_id,
   output logic             card_grant,
   // Network address
   input  wire logic [31:0] ip_saved,
   input  wire logic        ip_set,
   input  wire logic [31:0] ip_set_val,
   input  wire logic        factory_address_restore,
   output logic [31:0]      ip_addr,
   // Network indicators
   input  wire logic        phy_link,
   input  wire logic        phy_act,
   input  wire logic        phy_100m,
   output logic             led_green,
   output logic             led_yellow
);
   cpe_pkg::cpe_state_s s_ff, nxt_s;
   logic                rx_vld;
   logic                range_bad;
   logic [32:0]         end_sum;

   // Counters reload one below the bit time; half a bit centres the receiver
   localparam logic [11:0] BIT_LAST = 12'(BIT_CYC - 1);
   localparam logic [11:0] HALF_BIT = 12'(BIT_CYC / 2);

   // Scan all entries; a block anywhere overrides any enable
   function automatic logic check(input logic [cpe_pkg::ENTRIES-1:0][31:0] t, input logic [27:0] id);
      logic en, blk;
      en  = 1'b0;
      blk = 1'b0;
      for (int i = 0; i < cpe_pkg::ENTRIES; i++)
      begin
         if (t[i][cpe_pkg::TYPE_MSB:cpe_pkg::TYPE_LSB] == cpe_pkg::T_CARD_EN && t[i][27:0] == id)
            en = 1'b1;
         if (t[i][cpe_pkg::TYPE_MSB:cpe_pkg::TYPE_LSB] == cpe_pkg::T_GROUP_EN
             && t[i][cpe_pkg::GRP_MSB:cpe_pkg::GRP_LSB] == id[cpe_pkg::GRP_MSB:cpe_pkg::GRP_LSB])
            en = 1'b1;
         if (t[i][cpe_pkg::TYPE_MSB:cpe_pkg::TYPE_LSB] == cpe_pkg::T_CARD_BLK && t[i][27:0] == id)
            blk = 1'b1;
      end
      // Zero fields mark an unused identifier
      return en && !blk && id[cpe_pkg::GRP_MSB:cpe_pkg::GRP_LSB] != 14'h0000
             && id[cpe_pkg::MEM_MSB:0] != 14'h0000;
   endfunction : check

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_s     = s_ff;
      rx_vld    = 1'b0;
      range_bad = 1'b0;
      end_sum   = 33'h0;
      nxt_s.mem_we   = 1'b0;
      nxt_s.proc_rst = 1'b0;
      nxt_s.rx_s1    = cfg_rxd;
      nxt_s.rx_s2    = s_ff.rx_s1;
      nxt_s.ipr1     = factory_address_restore;
      nxt_s.ipr2     = s_ff.ipr1;
      nxt_s.ph1      = {phy_link, phy_act, phy_100m};
      nxt_s.ph2      = s_ff.ph1;

      // Receiver: centre-sampled 8N1
      if (!s_ff.rx_busy)
      begin
         if (!s_ff.rx_s2)
         begin
            nxt_s.rx_busy = 1'b1;
            nxt_s.rx_cnt  = HALF_BIT;
            nxt_s.rx_bit  = 4'h0;
         end
      end
      else if (s_ff.rx_cnt != 12'h000)
         nxt_s.rx_cnt = s_ff.rx_cnt - 12'h001;
      else
      begin
         nxt_s.rx_cnt = BIT_LAST;
         nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
         if (s_ff.rx_bit == 4'h0 && s_ff.rx_s2)
            nxt_s.rx_busy = 1'b0; // Glitch, not a start bit
         else if (s_ff.rx_bit >= 4'h1 && s_ff.rx_bit <= 4'h8)
            nxt_s.rx_sh = {s_ff.rx_s2, s_ff.rx_sh[7:1]};
         else if (s_ff.rx_bit == 4'h9)
         begin
            nxt_s.rx_busy = 1'b0;
            rx_vld        = s_ff.rx_s2; // framing errors dropped
         end
      end

      // Transmitter: idle line is the all-ones shifter
      if (s_ff.tx_busy)
      begin
         if (s_ff.tx_cnt != 12'h000)
            nxt_s.tx_cnt = s_ff.tx_cnt - 12'h001;
         else
         begin
            nxt_s.tx_cnt = BIT_LAST;
            nxt_s.tx_sh  = {1'b1, s_ff.tx_sh[9:1]};
            nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
            if (s_ff.tx_bit == 4'h9)
               nxt_s.tx_busy = 1'b0;
         end
      end

      // Command sequencer
      case (s_ff.st)
         cpe_pkg::S_IDLE:
            if (rx_vld)
            begin
               nxt_s.cmd[15:8] = s_ff.rx_sh;
               nxt_s.st        = cpe_pkg::S_ID2;
            end
         cpe_pkg::S_ID2:
            if (rx_vld)
            begin
               nxt_s.cmd[7:0] = s_ff.rx_sh;
               nxt_s.nib      = 3'h0;
               nxt_s.rc       = cpe_pkg::RC_UNKNOWN;
               nxt_s.st       = cpe_pkg::S_RESP;
               if ({s_ff.cmd[15:8], s_ff.rx_sh} == cpe_pkg::ID_RESTART)
                  nxt_s.rc = cpe_pkg::RC_OK;
               else if ({s_ff.cmd[15:8], s_ff.rx_sh} == cpe_pkg::ID_ERASE
                        || {s_ff.cmd[15:8], s_ff.rx_sh} == cpe_pkg::ID_PROGRAM)
                  nxt_s.st = cpe_pkg::S_PAR;
            end
         cpe_pkg::S_PAR:
            if (rx_vld)
            begin
               // Start then length, most significant byte first
               {nxt_s.addr, nxt_s.cnt} = {s_ff.addr[23:0], s_ff.cnt, s_ff.rx_sh};
               nxt_s.nib = s_ff.nib + 3'h1;
               end_sum   = {1'b0, nxt_s.addr} + {1'b0, nxt_s.cnt};
               range_bad = {1'b0, nxt_s.addr} > cpe_pkg::STORE_MAX || end_sum > cpe_pkg::STORE_MAX;
               if (s_ff.nib == 3'h7)
               begin
                  nxt_s.err = range_bad;
                  nxt_s.rc  = range_bad ? cpe_pkg::RC_RANGE : cpe_pkg::RC_OK;
                  nxt_s.st  = cpe_pkg::S_RESP;
                  if (s_ff.cmd == cpe_pkg::ID_ERASE)
                  begin
                     if (!range_bad)
                     begin
                        nxt_s.erase_req = 1'b1;
                        nxt_s.st        = cpe_pkg::S_ERASE;
                     end
                  end
                  else if (nxt_s.cnt > cpe_pkg::PROG_MAX)
                     nxt_s.rc = cpe_pkg::RC_RANGE; // Length above PROG_MAX, nothing drained
                  else if (nxt_s.cnt != 32'h0)
                     nxt_s.st = cpe_pkg::S_DATA;
               end
            end
         cpe_pkg::S_DATA:
            if (rx_vld)
            begin
               nxt_s.mem_we   = !s_ff.err;
               nxt_s.mem_addr = s_ff.addr[18:0];
               nxt_s.mem_data = s_ff.rx_sh;
               nxt_s.addr     = s_ff.addr + 32'h1;
               nxt_s.cnt      = s_ff.cnt - 32'h1;
               if (s_ff.cnt == 32'h1)
                  nxt_s.st = cpe_pkg::S_RESP;
            end
         cpe_pkg::S_ERASE:
            if (erase_done)
            begin
               nxt_s.erase_req = 1'b0;
               nxt_s.st        = cpe_pkg::S_RESP;
            end
         cpe_pkg::S_RESP:
            if (!s_ff.tx_busy)
            begin
               nxt_s.tx_sh   = {1'b1, s_ff.rc, 1'b0};
               nxt_s.tx_busy = 1'b1;
               nxt_s.tx_cnt  = BIT_LAST;
               nxt_s.tx_bit  = 4'h0;
               nxt_s.st      = cpe_pkg::S_WTX;
            end
         cpe_pkg::S_WTX:
            if (!s_ff.tx_busy)
               nxt_s.st = (s_ff.cmd == cpe_pkg::ID_RESTART) ? cpe_pkg::S_RST : cpe_pkg::S_IDLE;
         cpe_pkg::S_RST:
         begin
            nxt_s.proc_rst = 1'b1;
            nxt_s.cmd      = 16'h0000;
            nxt_s.st       = cpe_pkg::S_IDLE;
         end
         default:
            nxt_s.st = cpe_pkg::S_IDLE;
      endcase

      // Table is written from the user side, one entry per cycle
      if (tbl_wr)
         nxt_s.tbl[tbl_idx] = tbl_data;
      nxt_s.grant = check(s_ff.tbl, card_id);

      // Startup capture waits for the synchronised jumper
      if (s_ff.boot != 2'h3)
         nxt_s.boot = s_ff.boot + 2'h1;
      if (s_ff.boot == 2'h2)
         nxt_s.ip = s_ff.ipr2 ? cpe_pkg::IP_DEFAULT : ip_saved;
      else if (ip_set && s_ff.boot == 2'h3)
         nxt_s.ip = ip_set_val;

      nxt_s.blink = s_ff.blink + 1'b1;
      nxt_s.led_g = s_ff.ph2[2] && !(s_ff.ph2[1] && s_ff.blink[cpe_pkg::BLINK_W-1]);
      nxt_s.led_y = s_ff.ph2[2] && s_ff.ph2[0];
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         s_ff       <= '0;
         s_ff.tx_sh <= '1;
         s_ff.rx_s1 <= 1'b1;
         s_ff.rx_s2 <= 1'b1;
         s_ff.ip    <= cpe_pkg::IP_DEFAULT;
      end
      else
         s_ff <= nxt_s;
   end

   assign cfg_txd     = s_ff.tx_sh[0];
   assign store_wr    = s_ff.mem_we;
   assign store_addr  = s_ff.mem_addr;
   assign store_data  = s_ff.mem_data;
   assign erase_req   = s_ff.erase_req;
   assign erase_start = s_ff.addr;
   assign erase_len   = s_ff.cnt;
   assign proc_reset  = s_ff.proc_rst;
   assign card_grant  = s_ff.grant;
   assign ip_addr     = s_ff.ip;
   assign led_green   = s_ff.led_g;
   assign led_yellow  = s_ff.led_y;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_restart_after_tx: assert property (proc_reset |-> !s_ff.tx_busy && cfg_txd && $past(s_ff.st == cpe_pkg::S_RST))
      else $error("process reset while answer in flight");
   a_erase_in_range: assert property ($rose(erase_req) |-> {1'b0, erase_start} + {1'b0, erase_len} <= cpe_pkg::STORE_MAX)
      else $error("erase started out of range");
   a_erase_holds: assert property (erase_req && !erase_done |=> erase_req)
      else $error("erase request dropped early");
   a_write_no_err: assert property (store_wr |-> !s_ff.err && $past(s_ff.st == cpe_pkg::S_DATA))
      else $error("write during bad range");
   a_prog_count_lim: assert property (s_ff.st == cpe_pkg::S_DATA |-> s_ff.cnt <= cpe_pkg::PROG_MAX)
      else $error("program length above limit");
   a_zero_id_denied: assert property (card_id[13:0] == 14'h0 ##1 card_id[13:0] == 14'h0 |-> !card_grant)
      else $error("zero member granted");
   a_start_bit_len: assert property ($rose(s_ff.tx_busy) |-> !cfg_txd [*8])
      else $error("start bit too short");
   a_yellow_speed: assert property (s_ff.ph2[2] && s_ff.ph2[0] |=> led_yellow)
      else $error("yellow missing at 100M");
   a_ip_restore: assert property (s_ff.boot == 2'h2 && s_ff.ipr2 |=> ip_addr == cpe_pkg::IP_DEFAULT)
      else $error("restore jumper ignored");
   a_one_answer: assert property (s_ff.st == cpe_pkg::S_WTX && !s_ff.tx_busy |=> s_ff.st != cpe_pkg::S_RESP)
      else $error("second answer for one frame");

   c_program: cover property (store_wr ##1 s_ff.st == cpe_pkg::S_RESP);
   c_erase: cover property (erase_req && erase_done);
   c_restart: cover property (proc_reset);
   c_grant: cover property (card_grant);
endmodule : cpe_engine

// [test/cpe_host_model.sv]
module cpe_host_model
#(
   // Clocks per serial bit, matched to the device
   parameter int BIT_CYC = cpe_pkg::BIT_CYC
)
(
   // Clock
   input  wire logic mclk,
   // Serial lines
   input  wire logic cfg_txd,
   output logic      cfg_rxd
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] rx_q[$];
   logic       stop_bad;

   initial
   begin
      cfg_rxd  = 1'b1;
      stop_bad = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start bit, 8 data bits LSB first, one stop bit, idle high
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         cfg_rxd <= f[i];
         repeat (BIT_CYC) @(posedge mclk);
      end
   endtask : send_byte

   ////////////////////////////////////////////////////////////////////////////
   // Samples at bit centres; no flow control, so the device is never held off
   initial
   begin : rx_proc
      logic [7:0] sh;
      forever
      begin
         @(negedge cfg_txd);
         repeat (BIT_CYC / 2) @(posedge mclk);
         if (cfg_txd === 1'b0)
         begin
            for (int i = 0; i < 8; i++)
            begin
               repeat (BIT_CYC) @(posedge mclk);
               sh[i] = cfg_txd;
            end
            repeat (BIT_CYC) @(posedge mclk);
            if (cfg_txd !== 1'b1)
               stop_bad = 1'b1;
            rx_q.push_back(sh);
         end
      end
   end
endmodule : cpe_host_model

// [test/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk, rst_n, cfg_rxd, cfg_txd, store_wr, erase_req, erase_done, proc_reset;
   logic [18:0] store_addr;
   logic [7:0]  store_data;
   logic [31:0] erase_start, erase_len, tbl_data, ip_saved, ip_set_val, ip_addr;
   logic        tbl_wr, ip_set, factory_address_restore, card_grant;
   logic [5:0]  tbl_idx;
   logic [27:0] card_id;
   logic        phy_link, phy_act, phy_100m, led_green, led_yellow;
   int          fails, num_checks, cyc, wr_cnt, er_cyc;
   logic [26:0] wr_log [4];

   // Short bit time keeps whole frames inside the cycle budget; framing is unchanged
   localparam int BIT_T = 16;
   // Serial traffic dominates: about 60 bytes of 10 bits plus answers
   localparam int LIMIT = 20000;

   cpe_engine #(.BIT_CYC(BIT_T)) u_cpe_engine (.mclk(mclk), .rst_n(rst_n), .cfg_rxd(cfg_rxd), .cfg_txd(cfg_txd),
      .store_wr(store_wr), .store_addr(store_addr), .store_data(store_data), .erase_req(erase_req),
      .erase_start(erase_start), .erase_len(erase_len), .erase_done(erase_done),
      .proc_reset(proc_reset), .tbl_wr(tbl_wr), .tbl_idx(tbl_idx), .tbl_data(tbl_data),
      .card_id(card_id), .card_grant(card_grant), .ip_saved(ip_saved), .ip_set(ip_set),
      .ip_set_val(ip_set_val), .factory_address_restore(factory_address_restore),
      .ip_addr(ip_addr), .phy_link(phy_link), .phy_act(phy_act), .phy_100m(phy_100m),
      .led_green(led_green), .led_yellow(led_yellow));

   cpe_host_model #(.BIT_CYC(BIT_T)) u_cpe_host_model (.mclk(mclk), .cfg_txd(cfg_txd), .cfg_rxd(cfg_rxd));

   // Store and erase outputs watched mid-cycle, away from the launching edge
   always @(negedge mclk)
   begin
      if (store_wr === 1'b1)
      begin
         if (wr_cnt < 4)
            wr_log[wr_cnt] = {store_addr, store_data};
         wr_cnt++;
      end
      if (erase_req === 1'b1)
         er_cyc++;
   end

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         fails++;
         $display("[FAIL] %0t timeout", $time);
         report_and_stop();
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp

   task automatic look(input logic [27:0] id, input logic exp);
      card_id <= id;
      repeat (2) @(posedge mclk);
      #1;
      cmp(32'(card_grant), 32'(exp), "card grant");
   endtask : look

   task automatic wr_entry(input logic [5:0] idx, input logic [31:0] val);
      tbl_wr   <= 1'b1;
      tbl_idx  <= idx;
      tbl_data <= val;
      @(posedge mclk);
      tbl_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr_entry

   // Identifier, then start and length, most significant byte first
   task automatic send_head(input logic [15:0] id, input logic [31:0] addr, input logic [31:0] len);
      logic [63:0] p;
      p = {addr, len};
      @(posedge mclk);
      u_cpe_host_model.send_byte(id[15:8]);
      u_cpe_host_model.send_byte(id[7:0]);
      for (int i = 7; i >= 0; i--)
         u_cpe_host_model.send_byte(p[8*i +: 8]);
   endtask : send_head

   // Waits for the single answer of a frame and takes it off the queue
   task automatic get_answer(input logic [7:0] exp, input string what);
      for (int i = 0; i < 30 * BIT_T && u_cpe_host_model.rx_q.size() == 0; i++)
         @(posedge mclk);
      cmp(32'(u_cpe_host_model.rx_q.size()), 32'h1, "one answer");
      if (u_cpe_host_model.rx_q.size() != 0)
         cmp(32'(u_cpe_host_model.rx_q.pop_front()), 32'(exp), what);
      repeat (2 * BIT_T) @(posedge mclk);
   endtask : get_answer

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_program();
      @(posedge mclk);
      u_cpe_host_model.send_byte(8'h70);
      u_cpe_host_model.send_byte(8'h71);
      get_answer(cpe_pkg::RC_UNKNOWN, "unknown command");
      send_head(16'h7777, 32'h0005_fffe, 32'h0000_0002);
      u_cpe_host_model.send_byte(8'ha5);
      u_cpe_host_model.send_byte(8'h3c);
      get_answer(cpe_pkg::RC_OK, "program answer");
      cmp(32'(wr_cnt), 32'h2, "write count");
      cmp(32'(wr_log[0]), {5'h00, 19'h5_fffe, 8'ha5}, "first write");
      cmp(32'(wr_log[1]), {5'h00, 19'h5_ffff, 8'h3c}, "second write");
      send_head(16'h7777, 32'h0005_ffff, 32'h0000_0002);
      u_cpe_host_model.send_byte(8'h11);
      u_cpe_host_model.send_byte(8'h22);
      get_answer(cpe_pkg::RC_RANGE, "program past end");
      cmp(32'(wr_cnt), 32'h2, "no write past end");
      send_head(16'h7777, 32'h0000_0000, 32'h0000_0401);
      get_answer(cpe_pkg::RC_RANGE, "program too long");
      cmp(32'(wr_cnt), 32'h2, "no write too long");
      $display("test program done");
   endtask : test_program

   task automatic test_erase();
      send_head(16'h7765, 32'h0005_0000, 32'h0002_0000);
      get_answer(cpe_pkg::RC_RANGE, "erase past end");
      cmp(32'(er_cyc), 32'h0, "no erase past end");
      send_head(16'h7765, 32'h0001_0000, 32'h0005_0000);
      for (int i = 0; i < 4 * BIT_T && erase_req !== 1'b1; i++)
      begin
         @(posedge mclk);
         #1;
      end
      cmp(32'(erase_req), 32'h1, "erase request");
      cmp(erase_start, 32'h0001_0000, "erase start");
      cmp(erase_len, 32'h0005_0000, "erase length");
      repeat (3) @(posedge mclk);
      #1;
      cmp(32'(erase_req), 32'h1, "erase held");
      @(posedge mclk);
      erase_done <= 1'b1;
      @(posedge mclk);
      erase_done <= 1'b0;
      @(posedge mclk);
      #1;
      cmp(32'(erase_req), 32'h0, "erase released");
      get_answer(cpe_pkg::RC_OK, "erase answer");
      $display("test erase done");
   endtask : test_erase

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_card();
      wr_entry(6'h00, 32'h2000_4000);
      wr_entry(6'h01, 32'h1000_8003);
      wr_entry(6'h02, 32'h3000_4005);
      wr_entry(6'h03, 32'h0000_c001);
      wr_entry(6'h3f, 32'h1000_0001);
      look(28'h000_4001, 1'b1);
      look(28'h000_4005, 1'b0);
      look(28'h000_8003, 1'b1);
      look(28'h000_8004, 1'b0);
      look(28'h000_c001, 1'b0);
      look(28'h000_4000, 1'b0);
      look(28'h000_0001, 1'b0);
      $display("test card done");
   endtask : test_card

   task automatic test_ip();
      repeat (6) @(posedge mclk);
      #1;
      cmp(ip_addr, 32'h0a00_0005, "loaded address");
      @(posedge mclk);
      ip_set     <= 1'b1;
      ip_set_val <= 32'h0a00_0009;
      @(posedge mclk);
      ip_set <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      cmp(ip_addr, 32'h0a00_0009, "set address");
      @(posedge mclk);
      factory_address_restore <= 1'b1;
      rst_n                   <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      cmp(ip_addr, cpe_pkg::IP_DEFAULT, "restored address");
      look(28'h000_4001, 1'b0);
      $display("test ip done");
   endtask : test_ip

   task automatic test_leds();
      phy_link <= 1'b1;
      repeat (5) @(posedge mclk);
      #1;
      cmp(32'({led_green, led_yellow}), 32'h2, "link 10");
      phy_100m <= 1'b1;
      repeat (5) @(posedge mclk);
      #1;
      cmp(32'({led_green, led_yellow}), 32'h3, "link 100");
      phy_link <= 1'b0;
      phy_100m <= 1'b0;
      repeat (5) @(posedge mclk);
      #1;
      cmp(32'({led_green, led_yellow}), 32'h0, "no link");
      $display("test leds done");
   endtask : test_leds

   task automatic test_restart();
      @(posedge mclk);
      u_cpe_host_model.send_byte(8'h7a);
      u_cpe_host_model.send_byte(8'h7a);
      for (int i = 0; i < 30000 && proc_reset !== 1'b1; i++)
      begin
         @(posedge mclk);
         #1;
      end
      cmp(32'(proc_reset), 32'h1, "reset pulse");
      cmp(32'(u_cpe_host_model.rx_q.size()), 32'h1, "one answer");
      cmp(32'(u_cpe_host_model.rx_q[0]), 32'(cpe_pkg::RC_OK), "answer");
      cmp(32'(u_cpe_host_model.stop_bad), 32'h0, "stop bit");
      cmp(32'(cfg_txd), 32'h1, "line idle");
      @(posedge mclk);
      #1;
      cmp(32'(proc_reset), 32'h0, "pulse ends");
      cmp(ip_addr, cpe_pkg::IP_DEFAULT, "address kept");
      $display("test restart done");
   endtask : test_restart

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      fails      = 0;
      num_checks = 0;
      cyc        = 0;
      wr_cnt     = 0;
      er_cyc     = 0;
      rst_n      = 1'b0;
      erase_done = 1'b0;
      tbl_wr     = 1'b0;
      tbl_idx    = 6'h00;
      tbl_data   = 32'h0000_0000;
      card_id    = 28'h000_0000;
      ip_saved   = 32'h0a00_0005;
      ip_set     = 1'b0;
      ip_set_val = 32'h0000_0000;
      factory_address_restore = 1'b0;
      phy_link   = 1'b0;
      phy_act    = 1'b0;
      phy_100m   = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      cmp(ip_addr, cpe_pkg::IP_DEFAULT, "reset address");
      @(posedge mclk);
      rst_n <= 1'b1;
      test_card();
      test_ip();
      test_leds();
      test_program();
      test_erase();
      test_restart();
      report_and_stop();
   end
endmodule : tb
